// [core/gps_defines.vh]
// Constants for the gesture proximity sequencer
// Function
// - Drive up to three emitters, each selectable for an ordinary measurement.
// - A selected channel's result lands in that channel's own result register.
// - Host sets the gesture mode bit to 1; device treats it as gesture active.
// - One-shot gesture mode fires all three emitters, one result register each.
// - In one-shot mode the three-emitter sequence starts only after the host writes the trigger bit.
// - Sequence end sets gesture-ready flag and asserts interrupt when enabled.
// - Any enabled flag that is set holds the low-active interrupt pin low.
// - Reading the flag register clears set flags and releases the interrupt pin.
// - In one-shot mode no new data and standby unless trigger is written.
`ifndef GPS_DEFINES_VH
`define GPS_DEFINES_VH

// Register offsets
`define GPS_REG_CTRL 3'h0
`define GPS_REG_INT_EN 3'h1
`define GPS_REG_FLAG 3'h2
`define GPS_REG_FLAG_CLR 3'h3
`define GPS_REG_DATA1 3'h4
`define GPS_REG_DATA2 3'h5
`define GPS_REG_DATA3 3'h6

// Control fields
`define GPS_CTRL_GESTURE 0
`define GPS_CTRL_ONE_SHOT 1
`define GPS_CTRL_TRIGGER 2
`define GPS_CTRL_SEL_LO 3
`define GPS_CTRL_SEL_HI 4

// Flag fields
`define GPS_FLAG_GESTURE_READY 0
`define GPS_FLAG_MEAS_DONE 1
`define GPS_FLAG_W 2

// Reset values
`define GPS_CTRL_RST 5'h00
`define GPS_INT_EN_RST 2'h0

// Timing: converter clock edges per measurement
`define GPS_MEAS_EDGES 8

`endif

// [core/gps_meas.v]
// One emitter measurement paced by the converter clock
`timescale 1ns/1ps
`include "gps_defines.vh"
module gps_meas #(
  parameter DATA_W = 16,
  parameter MEAS_EDGES = `GPS_MEAS_EDGES
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Converter side, outside our clock domain
  input wire link_clk,
  input wire [DATA_W-1:0] adc_data,
  // Sequencer side
  input wire start,
  input wire [1:0] chan,
  output reg [2:0] emit_q,
  output reg done_q,
  output reg [DATA_W-1:0] result_q
);
  reg lclk_s1_q;
  reg lclk_s2_q;
  reg lclk_s3_q;
  reg [DATA_W-1:0] adc_s1_q;
  reg [DATA_W-1:0] adc_s2_q;
  reg [7:0] edge_cnt_q;
  reg active_q;
  wire lclk_rise;

  //////////////////////////////////////////////////////////////////////////
  // Synchronisers; the edge detector reads only the second stage onward
  always @(posedge sys_clk) begin
    lclk_s1_q <= link_clk;
    lclk_s2_q <= lclk_s1_q;
    lclk_s3_q <= lclk_s2_q;
    adc_s1_q <= adc_data;
    adc_s2_q <= adc_s1_q;
  end

  assign lclk_rise = lclk_s2_q & ~lclk_s3_q;

  //////////////////////////////////////////////////////////////////////////
  // Emitter on for a fixed count of converter edges, then sample
  always @(posedge sys_clk) begin
    if (rst) begin
      emit_q <= 3'h0;
      done_q <= 1'b0;
      result_q <= {DATA_W{1'b0}};
      edge_cnt_q <= 8'h00;
      active_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (start && !active_q) begin
        active_q <= 1'b1;
        edge_cnt_q <= 8'h00;
        emit_q <= 3'h1 << chan;
      end else if (active_q && lclk_rise) begin
        if (edge_cnt_q == MEAS_EDGES[7:0] - 8'h01) begin
          // Data word is sampled a full converter edge after it settled
          active_q <= 1'b0;
          emit_q <= 3'h0;
          done_q <= 1'b1;
          result_q <= adc_s2_q;
        end else begin
          edge_cnt_q <= edge_cnt_q + 8'h01;
        end
      end
    end
  end
endmodule // gps_meas

// [core/gps_seq.v]
// Gesture proximity sequencer with register port and interrupt
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "gps_defines.vh"
module gps_seq #(
  parameter DATA_W = 16,
  parameter MEAS_EDGES = `GPS_MEAS_EDGES
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Register port
  input wire [2:0] reg_addr,
  input wire [DATA_W-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [DATA_W-1:0] reg_rdata_q,
  // Converter side
  input wire link_clk,
  input wire [DATA_W-1:0] adc_data,
  // Emitter drivers and interrupt
  output wire [2:0] emit_q,
  output reg int_n_q
);
  localparam S_IDLE = 2'd0;
  localparam S_WAIT = 2'd1;
  localparam S_START = 2'd2;

  reg [4:0] ctrl_q;
  reg [4:0] ctrl_d;
  reg [`GPS_FLAG_W-1:0] int_en_q;
  reg [`GPS_FLAG_W-1:0] flag_q;
  reg [`GPS_FLAG_W-1:0] flag_d;
  reg [`GPS_FLAG_W-1:0] flag_set;
  reg [`GPS_FLAG_W-1:0] flag_clr;
  reg int_n_d;
  wire [DATA_W-1:0] data_w [0:2];
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [1:0] chan_q;
  reg [1:0] chan_d;
  reg start_d;
  reg trig_clr;
  reg [2:0] store_en;
  wire gesture_on;
  wire one_shot;
  wire trig_pend;
  wire [1:0] sel_chan;
  wire meas_done;
  wire [DATA_W-1:0] meas_result;
  genvar gi;

  //////////////////////////////////////////////////////////////////////////
  // Decoders shared by the control, enable, flag and result logic
  function reg_hit;
    input strobe;
    input [2:0] addr;
    input [2:0] idx;
    begin
      reg_hit = strobe && (addr == idx);
    end
  endfunction

  function [2:0] chan_onehot;
    input [1:0] chan;
    begin
      chan_onehot = 3'h1 << chan;
    end
  endfunction

  assign gesture_on = ctrl_q[`GPS_CTRL_GESTURE];
  assign one_shot = ctrl_q[`GPS_CTRL_ONE_SHOT];
  assign trig_pend = ctrl_q[`GPS_CTRL_TRIGGER];
  // Channel code 3 is not an emitter; fold it onto the third
  assign sel_chan = (ctrl_q[`GPS_CTRL_SEL_HI:`GPS_CTRL_SEL_LO] == 2'd3) ? 2'd2 :
    ctrl_q[`GPS_CTRL_SEL_HI:`GPS_CTRL_SEL_LO];

  //////////////////////////////////////////////////////////////////////////
  // Measurement engine
  gps_meas #(
    .DATA_W(DATA_W),
    .MEAS_EDGES(MEAS_EDGES)
  ) u_meas (
    .sys_clk(sys_clk),
    .rst(rst),
    .link_clk(link_clk),
    .adc_data(adc_data),
    .start(start_d),
    .chan(chan_q),
    .emit_q(emit_q),
    .done_q(meas_done),
    .result_q(meas_result)
  );

  //////////////////////////////////////////////////////////////////////////
  // Sequencer
  always @* begin
    state_d = state_q;
    chan_d = chan_q;
    start_d = 1'b0;
    trig_clr = 1'b0;
    store_en = 3'h0;
    flag_set = {`GPS_FLAG_W{1'b0}};
    case (state_q)
      S_IDLE: begin
        // One-shot mode stays in standby until the trigger is written
        if (!one_shot || trig_pend) begin
          state_d = S_START;
          chan_d = gesture_on ? 2'd0 : sel_chan;
        end
      end
      S_START: begin
        start_d = 1'b1;
        state_d = S_WAIT;
      end
      S_WAIT: begin
        if (meas_done) begin
          store_en = chan_onehot(chan_q);
          if (gesture_on && chan_q != 2'd2) begin
            chan_d = chan_q + 2'd1;
            state_d = S_START;
          end else begin
            state_d = S_IDLE;
            trig_clr = one_shot;
            if (gesture_on) begin
              flag_set[`GPS_FLAG_GESTURE_READY] = 1'b1;
            end else begin
              flag_set[`GPS_FLAG_MEAS_DONE] = 1'b1;
            end
          end
        end
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      state_q <= S_IDLE;
      chan_q <= 2'd0;
    end else begin
      state_q <= state_d;
      chan_q <= chan_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Result registers, one per emitter
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_data
      // One register per emitter keeps each word to a single driver
      reg [DATA_W-1:0] word_q;
      always @(posedge sys_clk) begin
        if (rst) begin
          word_q <= {DATA_W{1'b0}};
        end else if (store_en[gi]) begin
          word_q <= meas_result;
        end
      end
      assign data_w[gi] = word_q;
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // Control register; a trigger write in the finishing cycle is kept
  always @* begin
    ctrl_d = ctrl_q;
    if (trig_clr) begin
      ctrl_d[`GPS_CTRL_TRIGGER] = 1'b0;
    end
    if (reg_hit(reg_wr, reg_addr, `GPS_REG_CTRL)) begin
      ctrl_d = reg_wdata[4:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Flags: set wins over read-clear and write-clear
  always @* begin
    flag_clr = {`GPS_FLAG_W{1'b0}};
    if (reg_hit(reg_rd, reg_addr, `GPS_REG_FLAG)) begin
      flag_clr = {`GPS_FLAG_W{1'b1}};
    end
    if (reg_hit(reg_wr, reg_addr, `GPS_REG_FLAG_CLR)) begin
      flag_clr = flag_clr | reg_wdata[`GPS_FLAG_W-1:0];
    end
    flag_d = (flag_q & ~flag_clr) | flag_set;
    // Pin is low whenever an enabled flag is set
    int_n_d = ~|(flag_d & int_en_q);
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      ctrl_q <= `GPS_CTRL_RST;
      int_en_q <= `GPS_INT_EN_RST;
      flag_q <= {`GPS_FLAG_W{1'b0}};
      int_n_q <= 1'b1;
    end else begin
      ctrl_q <= ctrl_d;
      if (reg_hit(reg_wr, reg_addr, `GPS_REG_INT_EN)) begin
        int_en_q <= reg_wdata[`GPS_FLAG_W-1:0];
      end
      flag_q <= flag_d;
      int_n_q <= int_n_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read port, data one cycle after the strobe
  always @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata_q <= {DATA_W{1'b0}};
    end else if (reg_rd) begin
      case (reg_addr)
        `GPS_REG_CTRL: reg_rdata_q <= {{(DATA_W-5){1'b0}}, ctrl_q};
        `GPS_REG_INT_EN: reg_rdata_q <= {{(DATA_W-`GPS_FLAG_W){1'b0}}, int_en_q};
        `GPS_REG_FLAG: reg_rdata_q <= {{(DATA_W-`GPS_FLAG_W){1'b0}}, flag_q};
        `GPS_REG_DATA1: reg_rdata_q <= data_w[0];
        `GPS_REG_DATA2: reg_rdata_q <= data_w[1];
        `GPS_REG_DATA3: reg_rdata_q <= data_w[2];
        default: reg_rdata_q <= {DATA_W{1'b0}};
      endcase
    end else begin
      reg_rdata_q <= {DATA_W{1'b0}};
    end
  end
endmodule // gps_seq

// [sim/gps_seq_props.sv]
// Port assertions for the gesture proximity sequencer
`timescale 1ns/1ps
module gps_seq_props #(
  parameter DATA_W = 16,
  parameter MEAS_EDGES = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  // Outputs
  input wire logic [2:0] emit_q,
  input wire logic int_n_q
);
  ////////////////////////////////////////////////////////////////////////////////
  // Shadow of host-written mode and enable bits; the trigger is not shadowed
  // because the block clears it on its own
  logic [1:0] mode_q;
  logic [1:0] ien_q;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode_q <= 2'h0;
      ien_q <= 2'h0;
    end else if (reg_wr && reg_addr == 3'h0) begin
      mode_q <= reg_wdata[1:0];
    end else if (reg_wr && reg_addr == 3'h1) begin
      ien_q <= reg_wdata[1:0];
    end
  end
  // First emitter a control write lights: gesture starts at one, else the selection
  logic [2:0] want_q;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      want_q <= 3'h1;
    end else if (reg_wr && reg_addr == 3'h0) begin
      want_q <= (reg_wdata[0] || reg_wdata[4:3] == 2'h0) ? 3'h1 :
        ((reg_wdata[4:3] == 2'h1) ? 3'h2 : 3'h4);
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence seq_gap_then(logic [2:0] nxt);
    emit_q == 3'h0 ##[1:2] emit_q == nxt;
  endsequence
  chk_emit_onehot: assert property ($onehot0(emit_q))
    else $error("two emitters on");
  chk_emit_hold: assert property ($rose(emit_q[1]) |-> (emit_q == 3'h2) [*8])
    else $error("emitter dropped early");
  chk_trig_start: assert property (reg_wr && reg_addr == 3'h0 && reg_wdata[2]
    && mode_q[1] && emit_q == 3'h0 |-> ##[2:5] emit_q == want_q)
    else $error("no start after trigger");
  chk_next_emit: assert property (mode_q == 2'h3 && $fell(emit_q[0])
    |-> seq_gap_then(3'h2))
    else $error("wrong emitter order");
  chk_last_idle: assert property (mode_q == 2'h3 && $fell(emit_q[2])
    |-> (emit_q == 3'h0) [*8])
    else $error("no idle after sequence");
  chk_int_ready: assert property (mode_q == 2'h3 && ien_q[0] && $fell(emit_q[2])
    |-> ##[0:2] !int_n_q)
    else $error("no interrupt at ready");
  chk_int_masked: assert property (ien_q == 2'h0 && $past(ien_q) == 2'h0 |-> int_n_q)
    else $error("interrupt while disabled");
  chk_read_release: assert property (reg_rd && reg_addr == 3'h2 && emit_q == 3'h0
    |-> ##[1:2] int_n_q)
    else $error("interrupt held after read");
endmodule // gps_seq_props
bind gps_seq gps_seq_props #(.DATA_W(DATA_W), .MEAS_EDGES(MEAS_EDGES)) chk_u (.*);

// [sim/gps_conv_model.sv]
// Converter model: link clock and result only while an emitter is lit
`timescale 1ns/1ps
module gps_conv_model #(
  parameter int HALF_NS = 80
) (
  // Emitter drive and result tag
  input wire logic [2:0] emit_q,
  input wire logic [7:0] base,
  // Converter outputs
  output logic link_clk,
  output logic [15:0] adc_data
);
  initial begin
    link_clk = 1'b0;
    adc_data = 16'hffff;
  end
  logic [2:0] lit;
  // Result tells the lit emitter apart so a misfiled channel shows; the gap
  // between emitters is shorter than a half period, so any change ends the frame
  always begin
    wait (emit_q != 3'h0);
    lit = emit_q;
    adc_data = {base, 5'h00, emit_q};
    while (emit_q == lit) begin
      #(HALF_NS);
      if (emit_q == lit) begin
        link_clk = ~link_clk;
      end
    end
    link_clk = 1'b0;
    adc_data = ~adc_data;
  end
endmodule // gps_conv_model

// [sim/test_gesture_proximity_sequencer.sv]
// Self-checking bench for the gesture proximity sequencer
`timescale 1ns/1ps
module test_gesture_proximity_sequencer;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] base = 8'h3c;
  logic [15:0] reg_rdata_q, adc_data;
  logic [2:0] emit_q;
  logic link_clk, int_n_q;
  int failures = 0;
  int samples_checked = 0;
  always #5 sys_clk = ~sys_clk;
  gps_seq dut_u (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .link_clk(link_clk),
    .adc_data(adc_data), .emit_q(emit_q), .int_n_q(int_n_q));
  gps_conv_model conv_u (.emit_q(emit_q), .base(base), .link_clk(link_clk),
    .adc_data(adc_data));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [15:0] m, input logic [15:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata_q & m, exp);
  endtask
  // A measurement lasts about 130 cycles, so the bound covers a full sequence
  task automatic wait_emit(input logic [2:0] e);
    int n = 0;
    while (emit_q !== e && n < 3000) begin
      @(posedge sys_clk);
      #1 n++;
    end
    if (n == 3000) begin
      failures++;
      complete_run();
    end
  endtask
  task automatic int_after(input int c, input logic [15:0] exp);
    repeat (c) @(posedge sys_clk);
    #1 check({15'h0, int_n_q}, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    int_after(1, 16'h0001);
    rd(3'h1, 16'hffff, 16'h0000);
    rd(3'h7, 16'hffff, 16'h0000);
    wr(3'h0, 16'h0008);
    wait_emit(3'h2);
    wr(3'h0, 16'h000a);
    wait_emit(3'h0);
    repeat (300) @(posedge sys_clk);
    #1 check({13'h0, emit_q}, 16'h0000);
    rd(3'h5, 16'hffff, 16'h3c02);
    rd(3'h2, 16'h0003, 16'h0002);
    rd(3'h2, 16'h0003, 16'h0000);
    base <= 8'h71;
    wr(3'h1, 16'h0001);
    wr(3'h0, 16'h0007);
    wait_emit(3'h4);
    wait_emit(3'h0);
    int_after(3, 16'h0000);
    rd(3'h4, 16'hffff, 16'h7101);
    rd(3'h5, 16'hffff, 16'h7102);
    rd(3'h6, 16'hffff, 16'h7104);
    rd(3'h0, 16'h0007, 16'h0003);
    rd(3'h2, 16'h0001, 16'h0001);
    int_after(1, 16'h0001);
    rd(3'h2, 16'h0001, 16'h0000);
    base <= 8'h96;
    wr(3'h1, 16'h0000);
    wr(3'h0, 16'h0007);
    wait_emit(3'h4);
    wait_emit(3'h0);
    int_after(3, 16'h0001);
    rd(3'h6, 16'hffff, 16'h9604);
    wr(3'h1, 16'h0001);
    int_after(2, 16'h0000);
    wr(3'h3, 16'h0003);
    int_after(2, 16'h0001);
    base <= 8'ha5;
    wr(3'h0, 16'h001e);
    wait_emit(3'h4);
    wait_emit(3'h0);
    rd(3'h6, 16'hffff, 16'ha504);
    rd(3'h0, 16'h001f, 16'h001a);
    rd(3'h2, 16'h0003, 16'h0002);
    complete_run();
  end
endmodule // test_gesture_proximity_sequencer
